// ### rtl/fswd_map.svh
// register map, reset values and timing counts of the fail-safe watchdog
`ifndef FSWD_MAP_SVH
`define FSWD_MAP_SVH

// register byte offsets on the apb bus
`define FSWD_OFS_CTRL      8'h00
`define FSWD_OFS_CMD       8'h04
`define FSWD_OFS_RELOAD    8'h08
`define FSWD_OFS_COUNT     8'h0C
`define FSWD_OFS_STATUS    8'h10
`define FSWD_OFS_MASK      8'h14

// control register fields
`define FSWD_CTRL_SEL_BIT  0
`define FSWD_CTRL_EN_BIT   1
`define FSWD_CTRL_ST_LSB   2

// command register fields, write one to act
`define FSWD_CMD_SVC_BIT   0
`define FSWD_CMD_DIS_BIT   1
`define FSWD_CMD_ENA_BIT   2

// status and mask fields
`define FSWD_ST_PREWARN    0
`define FSWD_ST_RSTREQ     1

// prescaler ratios
`define FSWD_DIV_SLOW      16384
`define FSWD_DIV_FAST      256

// default interval after reset, with the system clock period
`define FSWD_INTERVAL_NS   6500000
`define FSWD_CLK_NS        100
`define FSWD_SEL_RST       1'b0
`define FSWD_MASK_RST      2'b00

// system clock cycles from prewarning to reset request
`define FSWD_PREWARN_CYC   64

`endif

// ### rtl/fswd_pkg.sv
// types of the fail-safe watchdog
package fswd_pkg;

	typedef enum logic [1:0] {
		FSWD_OFF,
		FSWD_RUN,
		FSWD_PREWARN,
		FSWD_RESET
	} fswd_state_e;

	typedef logic [15:0] fswd_cnt_t;

endpackage : fswd_pkg

// ### rtl/fswd_prescaler.sv
// divide-by-n prescaler producing a one-cycle tick enable
`timescale 1ns/10ps
`include "fswd_map.svh"

module fswd_prescaler #(
	parameter int DIV_SLOW = `FSWD_DIV_SLOW,
	parameter int DIV_FAST = `FSWD_DIV_FAST
) (
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	input  wire logic run_i,
	input  wire logic clear_i,
	input  wire logic sel_slow_i,
	output logic      tick_o
);
	import fswd_pkg::*;

	logic [13:0] cnt_ff;
	logic [13:0] limit;

	assign limit  = sel_slow_i ? 14'(DIV_SLOW - 1) : 14'(DIV_FAST - 1);
	assign tick_o = run_i && !clear_i && (cnt_ff == limit);

	// clear has priority so a service always starts a whole interval
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_ff <= 14'h0000;
		end else if (clear_i || tick_o) begin
			cnt_ff <= 14'h0000;
		end else if (run_i) begin
			cnt_ff <= cnt_ff + 14'h0001;
		end
	end

endmodule : fswd_prescaler

// ### rtl/fswd_top.sv
// fail-safe watchdog timer with apb register access
// Contract
// - enabled and counting after every reset
// - disable and enable commands accepted anytime; the code ignores both once in FSWD_RESET
// - overflow raises prewarning, then reset request
// - 16-bit counter, prescaler 16384 or 256
// - every load takes the reload register value
// - service reloads counter and clears prescaler
// - reset defaults give 6.5 ms at 10 MHz
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "fswd_map.svh"

module fswd_top #(
	parameter int DIV_SLOW    = `FSWD_DIV_SLOW,
	parameter int DIV_FAST    = `FSWD_DIV_FAST,
	parameter int INTERVAL_NS = `FSWD_INTERVAL_NS
) (
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [7:0]   paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output logic [31:0]       prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	output logic              irq_o,
	output logic              rst_req_o,
	output fswd_pkg::fswd_state_e state_o
);
	import fswd_pkg::*;

	// default ticks: interval over one fast prescaler period, rounded up
	localparam int DEF_TICKS  = (INTERVAL_NS / `FSWD_CLK_NS + DIV_FAST - 1) / DIV_FAST;
	localparam logic [15:0] RELOAD_RST = 16'(32'h0001_0000 - DEF_TICKS);
	localparam logic [6:0]  PW_LAST    = 7'(`FSWD_PREWARN_CYC - 1);

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	fswd_state_e state_ff;
	fswd_state_e nxt_state;
	fswd_cnt_t   count_ff;
	fswd_cnt_t   reload_ff;
	logic        sel_slow_ff;
	logic [1:0]  status_ff;
	logic [1:0]  mask_ff;
	logic [6:0]  pw_cnt_ff;
	logic        rst_req_ff;
	logic [31:0] prdata_ff;
	logic        tick;
	logic        presc_clr;
	logic        load;

	// bus decode
	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic cmd_svc;
	logic cmd_dis;
	logic cmd_ena;
	logic wr_ctrl;
	logic overflow;
	logic ev_prewarn;
	logic ev_rstreq;
	logic [1:0] st_clr;

	assign setup    = psel_i && !penable_i;
	assign access   = psel_i && penable_i;
	assign wr       = access && pwrite_i;
	assign rd       = access && !pwrite_i;
	assign mapped   = addr_hit(paddr_i, `FSWD_OFS_CTRL)   || addr_hit(paddr_i, `FSWD_OFS_CMD)
	                || addr_hit(paddr_i, `FSWD_OFS_RELOAD) || addr_hit(paddr_i, `FSWD_OFS_COUNT)
	                || addr_hit(paddr_i, `FSWD_OFS_STATUS) || addr_hit(paddr_i, `FSWD_OFS_MASK);
	// zero wait states; read data is caught in the setup cycle
	assign pready_o  = 1'b1;
	assign pslverr_o = access && !mapped;
	assign prdata_o  = prdata_ff;

	assign cmd_svc = wr && addr_hit(paddr_i, `FSWD_OFS_CMD) && pwdata_i[`FSWD_CMD_SVC_BIT];
	assign cmd_dis = wr && addr_hit(paddr_i, `FSWD_OFS_CMD) && pwdata_i[`FSWD_CMD_DIS_BIT];
	assign cmd_ena = wr && addr_hit(paddr_i, `FSWD_OFS_CMD) && pwdata_i[`FSWD_CMD_ENA_BIT];
	assign wr_ctrl = wr && addr_hit(paddr_i, `FSWD_OFS_CTRL);

	// a service after overflow cannot cancel the reset already on its way
	assign overflow   = (state_ff == FSWD_RUN) && tick && (count_ff == 16'hFFFF);
	// only FSWD_RESET ignores enable, prewarning does not; disable wins over a service
	assign load       = (cmd_ena && (state_ff != FSWD_RESET))
	                    || ((state_ff == FSWD_RUN) && cmd_svc && !cmd_dis);
	assign presc_clr  = load || (wr_ctrl && (pwdata_i[`FSWD_CTRL_SEL_BIT] != sel_slow_ff));
	assign ev_prewarn = overflow;
	assign ev_rstreq  = (state_ff == FSWD_PREWARN) && (pw_cnt_ff == PW_LAST) && !cmd_dis
	                    && !cmd_ena;
	assign st_clr     = (rd && addr_hit(paddr_i, `FSWD_OFS_STATUS)) ? prdata_ff[1:0] : 2'b00;

	fswd_prescaler #(
		.DIV_SLOW (DIV_SLOW),
		.DIV_FAST (DIV_FAST)
	) u_presc (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.run_i      ((state_ff == FSWD_RUN) && !cmd_dis),
		.clear_i    (presc_clr),
		.sel_slow_i (sel_slow_ff),
		.tick_o     (tick)
	);

	// enable wins over disable when both arrive in one write
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FSWD_OFF: begin
				if (cmd_ena) begin
					nxt_state = FSWD_RUN;
				end
			end
			FSWD_RUN: begin
				if (cmd_ena) begin
					nxt_state = FSWD_RUN;
				end else if (cmd_dis) begin
					nxt_state = FSWD_OFF;
				end else if (overflow) begin
					nxt_state = FSWD_PREWARN;
				end
			end
			FSWD_PREWARN: begin
				if (cmd_ena) begin
					nxt_state = FSWD_RUN;
				end else if (cmd_dis) begin
					nxt_state = FSWD_OFF;
				end else if (ev_rstreq) begin
					nxt_state = FSWD_RESET;
				end
			end
			FSWD_RESET: begin
				nxt_state = FSWD_RESET;
			end
			default: begin
				nxt_state = FSWD_OFF;
			end
		endcase
	end

	// reset leaves the watchdog running, no software step needed
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= FSWD_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_ff <= RELOAD_RST;
		end else if (load) begin
			count_ff <= reload_ff;
		end else if ((state_ff == FSWD_RUN) && tick) begin
			count_ff <= count_ff + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pw_cnt_ff <= 7'h00;
		end else if (state_ff == FSWD_PREWARN) begin
			pw_cnt_ff <= pw_cnt_ff + 7'h01;
		end else begin
			pw_cnt_ff <= 7'h00;
		end
	end

	// held until the system reset that it asks for
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_req_ff <= 1'b0;
		end else if (ev_rstreq) begin
			rst_req_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sel_slow_ff <= `FSWD_SEL_RST;
		end else if (wr_ctrl) begin
			sel_slow_ff <= pwdata_i[`FSWD_CTRL_SEL_BIT];
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reload_ff <= RELOAD_RST;
		end else if (wr && addr_hit(paddr_i, `FSWD_OFS_RELOAD)) begin
			reload_ff <= pwdata_i[15:0];
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mask_ff <= `FSWD_MASK_RST;
		end else if (wr && addr_hit(paddr_i, `FSWD_OFS_MASK)) begin
			mask_ff <= pwdata_i[1:0];
		end
	end

	// only bits already returned by the read are cleared, new events win
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_ff <= 2'b00;
		end else begin
			status_ff <= (status_ff & ~st_clr) | {ev_rstreq, ev_prewarn};
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup && !pwrite_i) begin
			case (paddr_i)
				`FSWD_OFS_CTRL: begin
					prdata_ff <= {28'h000_0000, 2'(state_ff), (state_ff != FSWD_OFF),
						sel_slow_ff};
				end
				`FSWD_OFS_RELOAD: begin
					prdata_ff <= {16'h0000, reload_ff};
				end
				`FSWD_OFS_COUNT: begin
					prdata_ff <= {16'h0000, count_ff};
				end
				`FSWD_OFS_STATUS: begin
					prdata_ff <= {30'h0000_0000, status_ff};
				end
				`FSWD_OFS_MASK: begin
					prdata_ff <= {30'h0000_0000, mask_ff};
				end
				default: begin
					prdata_ff <= 32'h0000_0000;
				end
			endcase
		end
	end

	assign irq_o     = |(status_ff & mask_ff);
	assign rst_req_o = rst_req_ff;
	assign state_o   = state_ff;

	// helper: cycles since the last prescaler restart
	logic [14:0] gap_ff;
	logic        rst_seen_ff;
	logic [6:0]  warn_age_ff;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gap_ff <= 15'h0000;
		end else if (tick || presc_clr || (state_ff != FSWD_RUN)) begin
			gap_ff <= 15'h0000;
		end else begin
			gap_ff <= gap_ff + 15'h0001;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_seen_ff <= 1'b1;
		end else if (tick || load) begin
			rst_seen_ff <= 1'b0;
		end
	end

	// helper: cycles spent in prewarning since the overflow, saturating
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			warn_age_ff <= 7'h00;
		end else if (overflow) begin
			warn_age_ff <= 7'h00;
		end else if ((state_ff == FSWD_PREWARN) && (warn_age_ff != 7'h7F)) begin
			warn_age_ff <= warn_age_ff + 7'h01;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	run_after_reset_a: assert property (
		$fell(sys_rst_i) |-> (state_ff == FSWD_RUN) && (count_ff == RELOAD_RST))
		else $error("watchdog not running after reset");

	disable_cmd_a: assert property (
		(cmd_dis && !cmd_ena && (state_ff inside {FSWD_RUN, FSWD_PREWARN}))
		|=> (state_ff == FSWD_OFF) && $stable(count_ff))
		else $error("disable command did not stop the watchdog");

	enable_cmd_a: assert property (
		(cmd_ena && (state_ff != FSWD_RESET)) |=> (state_ff == FSWD_RUN)
		&& (count_ff == $past(reload_ff)))
		else $error("enable command did not restart the watchdog");

	prewarn_then_reset_a: assert property (
		overflow |=> (state_ff == FSWD_PREWARN) && status_ff[`FSWD_ST_PREWARN]
		&& !rst_req_o)
		else $error("prewarning sequence broken");

	early_reset_a: assert property (
		(state_ff == FSWD_PREWARN) |-> !rst_req_o)
		else $error("reset request during prewarning");

	reset_req_bound_a: assert property (
		((state_ff == FSWD_PREWARN) && (warn_age_ff == PW_LAST) && !cmd_dis && !cmd_ena)
		|=> rst_req_o && (state_ff == FSWD_RESET))
		else $error("reset request late or missing");

	presc_ratio_a: assert property (
		tick |-> (gap_ff == (sel_slow_ff ? 15'(DIV_SLOW - 1) : 15'(DIV_FAST - 1))))
		else $error("prescaler period wrong");

	reload_take_a: assert property (
		(load && !cmd_ena) |=> (count_ff == $past(reload_ff)))
		else $error("load did not take reload value");

	service_clear_a: assert property (
		((state_ff == FSWD_RUN) && cmd_svc && !cmd_dis) |=> (gap_ff == 15'h0000)
		&& (count_ff == $past(reload_ff)) ##1 !tick)
		else $error("service did not restart interval");

	default_interval_a: assert property (
		$fell(sys_rst_i) |-> (16'(32'h0001_0000 - 32'(RELOAD_RST)) * DIV_FAST
		>= INTERVAL_NS / `FSWD_CLK_NS) && !sel_slow_ff && rst_seen_ff)
		else $error("reset defaults do not give the default interval");

	count_up_a: assert property (
		((state_ff == FSWD_RUN) && tick && !load && (count_ff != 16'hFFFF))
		|=> (count_ff == $past(count_ff) + 16'h0001))
		else $error("counter did not step up");

	irq_level_a: assert property (
		(status_ff & mask_ff) != 2'b00 |-> irq_o)
		else $error("interrupt not raised");

	overflow_c: cover property (overflow ##[1:70] rst_req_o);
	service_c:  cover property ((state_ff == FSWD_RUN) && cmd_svc);
	disable_c:  cover property (cmd_dis ##[1:20] cmd_ena);
	irq_c:      cover property ($rose(irq_o));

endmodule : fswd_top

// ### testbench/tb_fail_safe_watchdog_timer.sv
// self-checking bench of the fail-safe watchdog through its apb registers
`timescale 1ns/10ps
`include "fswd_map.svh"

module tb_fail_safe_watchdog_timer;
	import fswd_pkg::*;

	localparam int DSLOW = 64;
	localparam int DFAST = 4;
	localparam int INTV  = 4000;
	// default interval in fast ticks, and the reload that gives it
	localparam int          TICKS = (INTV / `FSWD_CLK_NS + DFAST - 1) / DFAST;
	localparam logic [31:0] RLD   = 32'h0001_0000 - TICKS;

	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [7:0]  paddr_i   = 8'h00;
	logic [31:0] pwdata_i  = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        irq_o;
	logic        rst_req_o;
	fswd_state_e state_o;
	logic [31:0] rd;
	logic        err;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          mark;

	fswd_top #(.DIV_SLOW(DSLOW), .DIV_FAST(DFAST), .INTERVAL_NS(INTV)) dut (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .irq_o(irq_o), .rst_req_o(rst_req_o),
		.state_o(state_o)
	);

	always #50 clk_sys_i = ~clk_sys_i;

	// cycles since reset release, for interval checks
	always @(posedge clk_sys_i) cyc <= sys_rst_i ? 0 : cyc + 1;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1 && k < 16) begin
			@(posedge clk_sys_i);
			k++;
		end
		if (k == 16) fail_count++;
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, rd, exp);
	endtask : rdchk

	task automatic stchk(input fswd_state_e s);
		chk("state", {30'h0, state_o}, {30'h0, s});
	endtask : stchk

	// bounded wait; the state check afterwards catches a timeout
	task automatic waitst(input fswd_state_e s, input int lim);
		int n;
		n = 0;
		while (state_o !== s && n < lim) begin
			@(posedge clk_sys_i);
			n++;
		end
		stchk(s);
	endtask : waitst

	task automatic do_reset();
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		repeat (12) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : do_reset

	task automatic t_overflow();
		do_reset();
		stchk(FSWD_RUN);
		rdchk("reload", `FSWD_OFS_RELOAD, RLD);
		rdchk("ctrl", `FSWD_OFS_CTRL, 32'h0000_0006);
		waitst(FSWD_PREWARN, 200);
		chk("interval", 32'(cyc >= TICKS * DFAST - 2 && cyc <= TICKS * DFAST + 3), 1);
		mark = cyc;
		chk("masked irq", irq_o, 1'b0);
		chk("early rst", rst_req_o, 1'b0);
		apb(1'b1, `FSWD_OFS_MASK, 32'h0000_0001);
		@(posedge clk_sys_i);
		chk("irq", irq_o, 1'b1);
		waitst(FSWD_RESET, 80);
		chk("warn span", 32'(cyc - mark >= 62 && cyc - mark <= 67), 1);
		chk("rst req", rst_req_o, 1'b1);
		rdchk("status", `FSWD_OFS_STATUS, 32'h0000_0003);
		rdchk("status clr", `FSWD_OFS_STATUS, 32'h0000_0000);
		chk("irq clr", irq_o, 1'b0);
		apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0004);
		@(posedge clk_sys_i);
		stchk(FSWD_RESET);
		$display("test overflow done");
	endtask : t_overflow

	task automatic t_service();
		do_reset();
		apb(1'b1, `FSWD_OFS_RELOAD, 32'h0000_FFF0);
		apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0001);
		rdchk("count load", `FSWD_OFS_COUNT, 32'h0000_FFF0);
		// services closer than one tick: count only holds if the prescaler clears
		repeat (12) apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0001);
		rdchk("count held", `FSWD_OFS_COUNT, 32'h0000_FFF0);
		repeat (20) begin
			repeat (30) @(posedge clk_sys_i);
			apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0001);
		end
		stchk(FSWD_RUN);
		repeat (13) @(posedge clk_sys_i);
		rdchk("fast count", `FSWD_OFS_COUNT, 32'h0000_FFF3);
		apb(1'b1, `FSWD_OFS_CTRL, 32'h0000_0001);
		apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0001);
		repeat (200) @(posedge clk_sys_i);
		rdchk("slow count", `FSWD_OFS_COUNT, 32'h0000_FFF3);
		apb(1'b1, `FSWD_OFS_RELOAD, 32'h0000_FFFF);
		apb(1'b1, `FSWD_OFS_CTRL, 32'h0000_0000);
		apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0001);
		waitst(FSWD_PREWARN, 8);
		$display("test service done");
	endtask : t_service

	task automatic t_onoff();
		logic [31:0] held;
		do_reset();
		apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0002);
		@(posedge clk_sys_i);
		stchk(FSWD_OFF);
		apb(1'b0, `FSWD_OFS_COUNT, 32'h0000_0000);
		held = rd;
		repeat (60) @(posedge clk_sys_i);
		rdchk("count stop", `FSWD_OFS_COUNT, held);
		apb(1'b1, `FSWD_OFS_CMD, 32'h0000_0006);
		@(posedge clk_sys_i);
		stchk(FSWD_RUN);
		rdchk("count ena", `FSWD_OFS_COUNT, RLD);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped err", err, 1'b1);
		chk("unmapped rd", rd, 32'h0000_0000);
		$display("test onoff done");
	endtask : t_onoff

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (6000) @(posedge clk_sys_i);
		fail_count++;
		test_done();
	end

	initial begin
		t_overflow();
		t_service();
		t_onoff();
		test_done();
	end

endmodule : tb_fail_safe_watchdog_timer
